// ===== logic/tprl_timer.sv
// 8-bit and 16-bit timer pair with reduced-resolution pwm
//
// Function
// - count no wider than pwm resolution after a tick or a write in pwm
// - upper count bits cleared on prescaled edge
// - excess written count bits discarded
// - compare bits above the selected resolution cleared at top load
// - compare clearing follows selected resolution
// - software can reset the prescaler
// - variable top value in pwm
// - phase, phase-frequency and fast pwm modes
// - counter zero has pwm and compare
// - counter one has compare a and b
// - pwm compare writes buffered until top
// - compare read returns active value
`timescale 1ns/1ps
`default_nettype none
`include "tprl_map.svh"
module tprl_timer
    import tprl_pkg::*;
(
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst_n,
    // prescaler control
    input  wire tprl_clk_sel_t clk_sel,
    input  wire logic          presc_clear,
    // counter one configuration
    input  wire tprl_c1_mode_t c1_mode,
    input  wire tprl_res_t     c1_res,
    input  wire logic          top_we,
    input  wire logic [15:0]   top_wdata,
    // counter one software writes
    input  wire logic          count_we,
    input  wire logic [15:0]   count_wdata,
    input  wire logic          cmp_a_we,
    input  wire logic          cmp_b_we,
    input  wire logic [15:0]   cmp_wdata,
    // counter zero configuration and writes
    input  wire logic          c0_pwm,
    input  wire logic          c0_cmp_we,
    input  wire logic [7:0]    c0_cmp_wdata,
    // counter one state
    output logic [15:0]        counter1_value,
    output logic [15:0]        compare_a_value,
    output logic [15:0]        compare_b_value,
    output logic               c1_top,
    output logic               oc1a,
    output logic               oc1b,
    // counter zero state
    output logic [7:0]         counter_zero_value,
    output logic [7:0]         counter_zero_compare,
    output logic               oc0
);
    tprl_presc_if pif ();

    logic [15:0] cnt_r, cnt_nxt, top_r, top_nxt;
    logic [15:0] cmp_a_r, cmp_a_nxt, cmp_b_r, cmp_b_nxt;
    logic [15:0] buf_a_r, buf_a_nxt, buf_b_r, buf_b_nxt;
    logic        down_r, down_nxt, top_ev_r, top_ev_nxt;
    logic        oc1a_r, oc1a_nxt, oc1b_r, oc1b_nxt;
    logic [7:0]  c0_r, c0_nxt, c0_cmp_r, c0_cmp_nxt, c0_buf_r, c0_buf_nxt;
    logic        oc0_r, oc0_nxt;
    logic        pwm, tick;
    logic [15:0] mask, top_eff, cnt_m;
    logic        at_top;

    // prescaler hookup
    assign pif.clk_sel     = clk_sel;
    assign pif.presc_clear = presc_clear;
    assign tick            = pif.tick;

    tprl_prescaler #(.PRE_W(10)) tprl_prescaler_i (
        .clock (clock),
        .rst_n (rst_n),
        .pif   (pif)
    );

    // allowed value bits for the selected resolution
    function automatic logic [15:0] res_mask(input logic p, input tprl_res_t r);
        logic [15:0] m;
        m = `TPRL_MASK_FULL;
        if (p) begin
            case (r)
                TPRL_RES_8:  m = `TPRL_MASK_8BIT;
                TPRL_RES_9:  m = `TPRL_MASK_9BIT;
                TPRL_RES_10: m = `TPRL_MASK_10BIT;
                default:     m = `TPRL_MASK_FULL;
            endcase
        end
        return m;
    endfunction

    // mode decode, mask and effective top
    assign pwm     = (c1_mode != TPRL_C1_NORMAL);
    assign mask    = res_mask(pwm, c1_res);
    assign top_eff = (c1_res == TPRL_RES_VAR) ? top_r : mask;
    assign cnt_m   = cnt_r & mask;
    assign at_top  = tick && pwm && (cnt_m >= top_eff);

    // counter one next state
    always_comb begin
        cnt_nxt    = cnt_r;
        down_nxt   = down_r;
        top_nxt    = top_we ? top_wdata : top_r;
        top_ev_nxt = at_top;
        if (count_we) begin
            cnt_nxt = count_wdata & mask;
        end else if (tick) begin
            case (c1_mode)
                TPRL_C1_NORMAL: cnt_nxt = cnt_r + 16'h0001;
                TPRL_C1_FAST:   cnt_nxt = at_top ? `TPRL_CNT_RESET : cnt_m + 16'h0001;
                default: begin
                    // up/down for both phase-correct flavours
                    if (!down_r && at_top) begin
                        down_nxt = 1'b1;
                        cnt_nxt  = cnt_m - 16'h0001;
                    end else if (down_r && cnt_m == `TPRL_CNT_RESET) begin
                        down_nxt = 1'b0;
                        cnt_nxt  = cnt_m + 16'h0001;
                    end else begin
                        cnt_nxt = down_r ? cnt_m - 16'h0001 : cnt_m + 16'h0001;
                    end
                end
            endcase
        end
        if (!pwm) begin
            down_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r    <= `TPRL_CNT_RESET;
            down_r   <= 1'b0;
            top_r    <= `TPRL_TOP_RESET;
            top_ev_r <= 1'b0;
        end else begin
            cnt_r    <= cnt_nxt;
            down_r   <= down_nxt;
            top_r    <= top_nxt;
            top_ev_r <= top_ev_nxt;
        end
    end

    // counter one compare channels with pwm double buffering
    always_comb begin
        buf_a_nxt = cmp_a_we ? cmp_wdata : buf_a_r;
        buf_b_nxt = cmp_b_we ? cmp_wdata : buf_b_r;
        cmp_a_nxt = cmp_a_r;
        cmp_b_nxt = cmp_b_r;
        if (!pwm) begin
            if (cmp_a_we) cmp_a_nxt = cmp_wdata;
            if (cmp_b_we) cmp_b_nxt = cmp_wdata;
        end else if (at_top) begin
            cmp_a_nxt = buf_a_r & mask;
            cmp_b_nxt = buf_b_r & mask;
        end
        // pwm level or toggle on match
        oc1a_nxt = oc1a_r;
        oc1b_nxt = oc1b_r;
        if (pwm) begin
            oc1a_nxt = (cnt_m < cmp_a_r);
            oc1b_nxt = (cnt_m < cmp_b_r);
        end else if (tick) begin
            oc1a_nxt = oc1a_r ^ (cnt_r == cmp_a_r);
            oc1b_nxt = oc1b_r ^ (cnt_r == cmp_b_r);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            buf_a_r <= `TPRL_CNT_RESET;
            buf_b_r <= `TPRL_CNT_RESET;
            cmp_a_r <= `TPRL_CNT_RESET;
            cmp_b_r <= `TPRL_CNT_RESET;
            oc1a_r  <= 1'b0;
            oc1b_r  <= 1'b0;
        end else begin
            buf_a_r <= buf_a_nxt;
            buf_b_r <= buf_b_nxt;
            cmp_a_r <= cmp_a_nxt;
            cmp_b_r <= cmp_b_nxt;
            oc1a_r  <= oc1a_nxt;
            oc1b_r  <= oc1b_nxt;
        end
    end

    // counter zero: 8-bit, single compare, fast pwm or toggle
    always_comb begin
        c0_nxt     = tick ? c0_r + 8'h01 : c0_r;
        c0_buf_nxt = c0_cmp_we ? c0_cmp_wdata : c0_buf_r;
        c0_cmp_nxt = c0_cmp_r;
        oc0_nxt    = oc0_r;
        if (!c0_pwm) begin
            if (c0_cmp_we) c0_cmp_nxt = c0_cmp_wdata;
            if (tick) oc0_nxt = oc0_r ^ (c0_r == c0_cmp_r);
        end else begin
            if (tick && c0_r == `TPRL_C0_TOP) c0_cmp_nxt = c0_buf_r;
            oc0_nxt = (c0_r < c0_cmp_r);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            c0_r     <= `TPRL_C0_RESET;
            c0_buf_r <= `TPRL_C0_RESET;
            c0_cmp_r <= `TPRL_C0_RESET;
            oc0_r    <= 1'b0;
        end else begin
            c0_r     <= c0_nxt;
            c0_buf_r <= c0_buf_nxt;
            c0_cmp_r <= c0_cmp_nxt;
            oc0_r    <= oc0_nxt;
        end
    end

    // outputs straight from flip-flops
    assign counter1_value       = cnt_r;
    assign compare_a_value      = cmp_a_r;
    assign compare_b_value      = cmp_b_r;
    assign c1_top               = top_ev_r;
    assign oc1a                 = oc1a_r;
    assign oc1b                 = oc1b_r;
    assign counter_zero_value   = c0_r;
    assign counter_zero_compare = c0_cmp_r;
    assign oc0                  = oc0_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_pwm_tick;
        pwm && tick && !count_we && (c1_res != TPRL_RES_VAR);
    endsequence
    sequence s_pwm_write_a;
        pwm && cmp_a_we && !at_top;
    endsequence

    a_count_width_tick: assert property (s_pwm_tick |=>
        (cnt_r & ~$past(mask)) == 16'h0000)
        else $error("count exceeds pwm resolution after tick");
    a_count_write_drop: assert property (count_we && pwm |=>
        cnt_r == ($past(count_wdata) & $past(mask)))
        else $error("excess count bits kept on write");
    a_cmp_top_load: assert property (pwm && at_top |=>
        cmp_a_r == ($past(buf_a_r) & $past(mask)))
        else $error("compare a not masked at top load");
    a_cmp_read_active: assert property (s_pwm_write_a ##1 (pwm && !at_top) |=>
        $stable(compare_a_value))
        else $error("buffered compare leaked before top");
    a_cmp_full_width: assert property (!pwm && cmp_b_we |=>
        compare_b_value == $past(cmp_wdata))
        else $error("normal mode compare not full width");
    a_fast_wrap_zero: assert property (c1_mode == TPRL_C1_FAST && at_top && !count_we |=>
        (cnt_r == 16'h0000) && c1_top)
        else $error("fast pwm did not wrap at top");
    a_phase_turn: assert property ((c1_mode == TPRL_C1_PHASE) && at_top && !count_we |=>
        down_r)
        else $error("phase pwm did not turn at top");
    a_c0_pwm_level: assert property (c0_pwm |=> oc0 == ($past(c0_r) < $past(c0_cmp_r)))
        else $error("counter zero pwm level wrong");
endmodule
`default_nettype wire

// ===== logic/tprl_map.svh
// constants for the reduced-resolution pwm timer pair
`ifndef TPRL_MAP_SVH
`define TPRL_MAP_SVH
`define TPRL_MASK_8BIT   16'h00ff
`define TPRL_MASK_9BIT   16'h01ff
`define TPRL_MASK_10BIT  16'h03ff
`define TPRL_MASK_FULL   16'hffff
`define TPRL_CNT_RESET   16'h0000
`define TPRL_TOP_RESET   16'hffff
`define TPRL_C0_TOP      8'hff
`define TPRL_C0_RESET    8'h00
`define TPRL_PRE_RESET   10'h000
`define TPRL_DIV8_BITS   3
`define TPRL_DIV64_BITS  6
`define TPRL_DIV256_BITS 8
`define TPRL_DIV1024_BITS 10
`endif

// ===== logic/tprl_pkg.sv
// types for the reduced-resolution pwm timer pair
package tprl_pkg;
    typedef enum logic [1:0] {
        TPRL_C1_NORMAL     = 2'b00,
        TPRL_C1_PHASE      = 2'b01,
        TPRL_C1_PHASE_FREQ = 2'b10,
        TPRL_C1_FAST       = 2'b11
    } tprl_c1_mode_t;
    typedef enum logic [1:0] {
        TPRL_RES_8   = 2'b00,
        TPRL_RES_9   = 2'b01,
        TPRL_RES_10  = 2'b10,
        TPRL_RES_VAR = 2'b11
    } tprl_res_t;
    typedef enum logic [2:0] {
        TPRL_CLK_STOP    = 3'b000,
        TPRL_CLK_DIV1    = 3'b001,
        TPRL_CLK_DIV8    = 3'b010,
        TPRL_CLK_DIV64   = 3'b011,
        TPRL_CLK_DIV256  = 3'b100,
        TPRL_CLK_DIV1024 = 3'b101
    } tprl_clk_sel_t;
endpackage

// ===== logic/tprl_presc_if.sv
// link between the timer core and its shared prescaler
`timescale 1ns/1ps
`default_nettype none
interface tprl_presc_if;
    import tprl_pkg::*;
    tprl_clk_sel_t clk_sel;
    logic          presc_clear;
    logic          tick;
    modport prescaler (input clk_sel, input presc_clear, output tick);
    modport timer     (output clk_sel, output presc_clear, input tick);
endinterface
`default_nettype wire

// ===== logic/tprl_prescaler.sv
// shared clock prescaler producing the timer count tick
`timescale 1ns/1ps
`default_nettype none
`include "tprl_map.svh"
module tprl_prescaler
    import tprl_pkg::*;
#(
    parameter int PRE_W = 10
) (
    // clock and reset
    input  wire logic      clock,
    input  wire logic      rst_n,
    // timer side
    tprl_presc_if.prescaler pif
);
    logic [PRE_W-1:0] pre_r;
    logic [PRE_W-1:0] pre_nxt;
    logic             tick_r;
    logic             tick_nxt;

    // true when the low n bits of the prescale count are all ones
    function automatic logic low_ones(input logic [PRE_W-1:0] v, input int n);
        logic r;
        r = 1'b1;
        for (int i = 0; i < PRE_W; i++) begin
            if (i < n && !v[i]) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction

    // divider count, cleared on software request
    always_comb begin
        pre_nxt  = pif.presc_clear ? PRE_W'(`TPRL_PRE_RESET) : pre_r + 1'b1;
        tick_nxt = 1'b0;
        if (!pif.presc_clear) begin
            case (pif.clk_sel)
                TPRL_CLK_STOP:    tick_nxt = 1'b0;
                TPRL_CLK_DIV1:    tick_nxt = 1'b1;
                TPRL_CLK_DIV8:    tick_nxt = low_ones(pre_r, `TPRL_DIV8_BITS);
                TPRL_CLK_DIV64:   tick_nxt = low_ones(pre_r, `TPRL_DIV64_BITS);
                TPRL_CLK_DIV256:  tick_nxt = low_ones(pre_r, `TPRL_DIV256_BITS);
                TPRL_CLK_DIV1024: tick_nxt = low_ones(pre_r, `TPRL_DIV1024_BITS);
                default:          tick_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pre_r  <= PRE_W'(`TPRL_PRE_RESET);
            tick_r <= 1'b0;
        end else begin
            pre_r  <= pre_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign pif.tick = tick_r;

    a_presc_clear: assert property (@(posedge clock) disable iff (!rst_n)
        pif.presc_clear |=> (pre_r == `TPRL_PRE_RESET) && !tick_r)
        else $error("prescaler not cleared on request");
endmodule
`default_nettype wire

// ===== test/tprl_timer_tb.sv
// self-checking bench for the reduced-resolution pwm timer pair
`timescale 1ns/1ps
`default_nettype none
module tprl_timer_tb;
    import tprl_pkg::*;
    logic          clock;
    logic          rst_n;
    tprl_clk_sel_t clk_sel;
    logic          presc_clear;
    tprl_c1_mode_t c1_mode;
    tprl_res_t     c1_res;
    logic          top_we, count_we, cmp_a_we, cmp_b_we, c0_pwm, c0_cmp_we;
    logic [15:0]   top_wdata, count_wdata, cmp_wdata;
    logic [7:0]    c0_cmp_wdata;
    logic [15:0]   counter1_value, compare_a_value, compare_b_value;
    logic          c1_top, oc1a, oc1b, oc0;
    logic [7:0]    counter_zero_value, counter_zero_compare;
    int            n_fail = 0;
    int            samples_checked = 0;
    logic [15:0]   mask [3] = '{16'h00ff, 16'h01ff, 16'h03ff};
    int            spacing [4] = '{8, 64, 256, 1024};

    tprl_timer tprl_timer_i (
        .clock(clock), .rst_n(rst_n), .clk_sel(clk_sel), .presc_clear(presc_clear),
        .c1_mode(c1_mode), .c1_res(c1_res), .top_we(top_we), .top_wdata(top_wdata),
        .count_we(count_we), .count_wdata(count_wdata), .cmp_a_we(cmp_a_we),
        .cmp_b_we(cmp_b_we), .cmp_wdata(cmp_wdata), .c0_pwm(c0_pwm),
        .c0_cmp_we(c0_cmp_we), .c0_cmp_wdata(c0_cmp_wdata),
        .counter1_value(counter1_value), .compare_a_value(compare_a_value),
        .compare_b_value(compare_b_value), .c1_top(c1_top), .oc1a(oc1a), .oc1b(oc1b),
        .counter_zero_value(counter_zero_value),
        .counter_zero_compare(counter_zero_compare), .oc0(oc0));

    // 125 mhz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic end_of_test();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // a wait that used up its bound ends the run as a failure
    task automatic bound_check(input int i, input int lim);
        if (i >= lim) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, i, lim);
            end_of_test();
        end
    endtask

    // inputs move 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask

    task automatic do_reset();
        rst_n = 1'b0; clk_sel = TPRL_CLK_STOP; presc_clear = 1'b0;
        c1_mode = TPRL_C1_NORMAL; c1_res = TPRL_RES_8; c0_pwm = 1'b0;
        {top_we, count_we, cmp_a_we, cmp_b_we, c0_cmp_we} = 5'h00;
        top_wdata = 16'h0000; count_wdata = 16'h0000; cmp_wdata = 16'h0000;
        c0_cmp_wdata = 8'h00;
        cyc(3);
        rst_n = 1'b1;
    endtask

    task automatic write_count(input logic [15:0] v);
        count_we = 1'b1; count_wdata = v;
        cyc(1);
        count_we = 1'b0;
        cyc(1);
    endtask

    // reset values and written count width per resolution
    task automatic scen_count_width();
        do_reset();
        check(counter1_value, 16'h0000);
        check(compare_a_value | compare_b_value, 16'h0000);
        for (int r = 0; r < 3; r++) begin
            c1_mode = TPRL_C1_FAST; c1_res = tprl_res_t'(r);
            write_count(16'hffff);
            check(counter1_value, mask[r]);
            c1_mode = TPRL_C1_NORMAL;
            write_count(16'hffff);
            check(counter1_value, 16'hffff);
            c1_mode = TPRL_C1_FAST; clk_sel = TPRL_CLK_DIV8;
            cyc(12);
            check(counter1_value & ~mask[r], 16'h0000);
            clk_sel = TPRL_CLK_STOP;
        end
    endtask

    // buffered compare loads at top, masked by resolution, every pwm mode
    task automatic scen_compare_load();
        int i;
        for (int m = 1; m < 4; m++) begin
            for (int r = 0; r < 3; r++) begin
                do_reset();
                c1_mode = tprl_c1_mode_t'(m); c1_res = tprl_res_t'(r);
                write_count(mask[r]);
                cmp_a_we = 1'b1; cmp_wdata = 16'hffff;
                cyc(1);
                cmp_a_we = 1'b0; cmp_b_we = 1'b1; cmp_wdata = 16'ha5a5;
                cyc(1);
                cmp_b_we = 1'b0;
                cyc(1);
                check(compare_a_value, 16'h0000);
                check(compare_b_value, 16'h0000);
                clk_sel = TPRL_CLK_DIV1;
                for (i = 0; i < 64 && c1_top !== 1'b1; i++) cyc(1);
                if (c1_top !== 1'b1) begin
                    check(16'h0000, 16'h0001);
                    end_of_test();
                end
                check(compare_a_value, mask[r]);
                check(compare_b_value, 16'ha5a5 & mask[r]);
                cyc(1);
                check(16'(oc1a), 16'h0001);
                check(16'(oc1b), 16'(m == 3));
            end
        end
    endtask

    // non-pwm compare takes effect directly at full width
    task automatic scen_normal_compare();
        do_reset();
        cmp_a_we = 1'b1; cmp_wdata = 16'hc3e1;
        cyc(1);
        cmp_a_we = 1'b0;
        cyc(1);
        check(compare_a_value, 16'hc3e1);
    endtask

    // divider spacing for the div8, div64, div256 and div1024 choices, then prescaler clear
    task automatic scen_prescaler();
        logic [15:0] v;
        int          i;
        do_reset();
        for (int s = 3; s >= 0; s--) begin
            clk_sel = tprl_clk_sel_t'(s + 2);
            v = counter1_value;
            for (i = 0; i < 2100 && counter1_value === v; i++) cyc(1);
            bound_check(i, 2100);
            v = counter1_value;
            for (i = 0; i < 2100 && counter1_value === v; i++) cyc(1);
            bound_check(i, 2100);
            check(16'(i), 16'(spacing[s]));
        end
        presc_clear = 1'b1;
        v = counter1_value;
        cyc(24);
        check(counter1_value, v);
        presc_clear = 1'b0;
        for (i = 0; i < 20 && counter1_value === v; i++) cyc(1);
        bound_check(i, 20);
        check(16'(counter1_value != v), 16'h0001);
        check(16'(i), 16'h0009);
    endtask

    // variable top bounds the count
    task automatic scen_var_top();
        int tops;
        tops = 0;
        do_reset();
        c1_mode = TPRL_C1_FAST; c1_res = TPRL_RES_VAR;
        top_we = 1'b1; top_wdata = 16'h0010;
        cyc(1);
        top_we = 1'b0; clk_sel = TPRL_CLK_DIV1;
        repeat (60) begin
            cyc(1);
            if (counter1_value > 16'h0010) check(counter1_value, 16'h0010);
            if (c1_top === 1'b1) tops++;
        end
        check(16'(tops >= 2), 16'h0001);
    endtask

    // counter zero pwm compare and output
    task automatic scen_counter_zero();
        int i;
        do_reset();
        c0_pwm = 1'b1; c0_cmp_we = 1'b1; c0_cmp_wdata = 8'h80;
        cyc(1);
        c0_cmp_we = 1'b0; clk_sel = TPRL_CLK_DIV1;
        for (i = 0; i < 300 && counter_zero_compare !== 8'h80; i++) cyc(1);
        bound_check(i, 300);
        check(16'(counter_zero_compare), 16'h0080);
        for (i = 0; i < 300 && counter_zero_value !== 8'h40; i++) cyc(1);
        bound_check(i, 300);
        check(16'(oc0), 16'h0001);
        for (i = 0; i < 300 && counter_zero_value !== 8'hc0; i++) cyc(1);
        bound_check(i, 300);
        check(16'(oc0), 16'h0000);
    endtask

    initial begin
        do_reset();
        scen_count_width();
        scen_compare_load();
        scen_normal_compare();
        scen_prescaler();
        scen_var_top();
        scen_counter_zero();
        end_of_test();
    end
endmodule
`default_nettype wire
